// ### src/fpe_command_fsm.sv
/*
  Command next-state logic for buffered program and erase (a word program in ready is ignored),
  including the word and buffered program paths nested inside an
  erase suspend, and the per-partition read mode.
  Assumes bus writes arrive already synchronous to i_mclk as a one
  cycle strobe, and that o_op_start pulses are consumed by a write
  state machine which answers with i_op_done.
*/
// What this block does
// RULE1 - Load 2 repeats until the announced count loads
// RULE2 - Word program in erase suspend enters setup
// RULE3 - Next write is data, enters busy state
// RULE4 - Suspend during nested program suspends both operations
// RULE5 - Status, clear, ID writes keep nested busy
// RULE6 - Only one partition programs or erases
// RULE7 - Partition read modes persist, never steer state
// RULE8 - Buffered program starts only on confirm
`timescale 1ns/10ps

module fpe_command_fsm #(
  parameter int NUM_PART = 8
) (
  // Clock and reset
  input  wire logic                      i_mclk,
  input  wire logic                      i_arst_n,
  // Host bus write
  input  wire logic                      i_wr,
  input  wire fpe_pkg::fpe_write_type    i_wr_word,
  // Write state machine handshake
  input  wire logic                      i_op_done,
  // State and events
  output fpe_pkg::fpe_state_type         o_state,
  output logic                           o_op_start,
  output logic                           o_error,
  output logic [fpe_pkg::PART_W-1:0]     o_busy_part,
  output logic [2*NUM_PART-1:0]          o_read_mode
);

  fpe_pkg::fpe_state_type state;
  fpe_pkg::fpe_state_type next_state;
  logic [fpe_pkg::CNT_W-1:0] count;
  logic [fpe_pkg::CNT_W-1:0] next_count;
  logic [fpe_pkg::PART_W-1:0] busy_part;
  logic [2*NUM_PART-1:0] read_mode;
  logic op_start;
  logic error;
  logic next_start;
  logic next_error;

  wire logic [7:0] cmd = i_wr_word.data[7:0];
  wire logic is_wp   = cmd == fpe_pkg::CMD_WORD_PROG_A ||
                       cmd == fpe_pkg::CMD_WORD_PROG_B;
  wire logic is_bp   = cmd == fpe_pkg::CMD_BUF_PROG;
  wire logic is_conf = cmd == fpe_pkg::CMD_CONFIRM;
  wire logic is_susp = cmd == fpe_pkg::CMD_SUSPEND;
  wire logic is_ers  = cmd == fpe_pkg::CMD_ERASE_SETUP;
  wire logic load_last = count == '0;
  // Words written while a load or program is collecting data can hold
  // any pattern, so they must never be taken as read mode commands.
  wire logic is_data = state inside {fpe_pkg::ST_BP_SETUP,
                                     fpe_pkg::ST_BP_LOAD1,
                                     fpe_pkg::ST_BP_LOAD2,
                                     fpe_pkg::ST_WP_SETUP_ES,
                                     fpe_pkg::ST_BP_SETUP_ES,
                                     fpe_pkg::ST_BP_LOAD1_ES,
                                     fpe_pkg::ST_BP_LOAD2_ES};

  // Read mode a command selects; keeps the old mode for other codes.
  function automatic logic [1:0] mode_of(input logic [7:0] c,
                                         input logic [1:0] old);
    case (c)
      fpe_pkg::CMD_READ_ARRAY:  mode_of = fpe_pkg::RMODE_ARRAY;
      fpe_pkg::CMD_READ_ID:     mode_of = fpe_pkg::RMODE_ID;
      fpe_pkg::CMD_QUERY:       mode_of = fpe_pkg::RMODE_QUERY;
      fpe_pkg::CMD_READ_STATUS: mode_of = fpe_pkg::RMODE_STATUS;
      default:                  mode_of = old;
    endcase
  endfunction

  always_comb
  begin
    next_state = state;
    next_count = count;
    next_start = 1'b0;
    next_error = 1'b0;
    if (i_wr)
    begin
      case (state)
        fpe_pkg::ST_READY:
        begin
          if (is_wp)
            next_state = fpe_pkg::ST_READY;
          else if (is_bp)
            next_state = fpe_pkg::ST_BP_SETUP;
          else if (is_ers)
            next_state = fpe_pkg::ST_ERASE_SETUP;
        end
        fpe_pkg::ST_BP_SETUP:
          next_state = fpe_pkg::ST_BP_LOAD1;
        fpe_pkg::ST_BP_SETUP_ES:
          next_state = fpe_pkg::ST_BP_LOAD1_ES;
        fpe_pkg::ST_BP_LOAD1, fpe_pkg::ST_BP_LOAD1_ES:
        begin
          // The word count is written as N-1, so zero means one word.
          next_count = i_wr_word.data[fpe_pkg::CNT_W-1:0];
          next_state = (state == fpe_pkg::ST_BP_LOAD1) ?
                       fpe_pkg::ST_BP_LOAD2 : fpe_pkg::ST_BP_LOAD2_ES;
        end
        fpe_pkg::ST_BP_LOAD2, fpe_pkg::ST_BP_LOAD2_ES:
        begin
          if (load_last) // [RULE1]
            next_state = (state == fpe_pkg::ST_BP_LOAD2) ?
                         fpe_pkg::ST_BP_CONFIRM : fpe_pkg::ST_BP_CONFIRM_ES;
          else
            next_count = count - 1'b1; // [RULE1]
        end
        fpe_pkg::ST_BP_CONFIRM:
        begin
          next_start = is_conf; // [RULE8]
          next_error = !is_conf;
          next_state = is_conf ? fpe_pkg::ST_BP_BUSY : fpe_pkg::ST_READY;
        end
        fpe_pkg::ST_BP_CONFIRM_ES:
        begin
          next_start = is_conf; // [RULE8]
          next_error = !is_conf;
          next_state = is_conf ? fpe_pkg::ST_BP_BUSY_ES
                               : fpe_pkg::ST_ERASE_SUSPEND;
        end
        fpe_pkg::ST_BP_BUSY:
          if (is_susp)
            next_state = fpe_pkg::ST_BP_SUSPEND;
        fpe_pkg::ST_BP_SUSPEND:
          if (is_conf)
            next_state = fpe_pkg::ST_BP_BUSY;
        fpe_pkg::ST_BP_BUSY_ES:
          if (is_susp)
            next_state = fpe_pkg::ST_BP_SUSPEND_ES;
        fpe_pkg::ST_BP_SUSPEND_ES:
          if (is_conf)
            next_state = fpe_pkg::ST_BP_BUSY_ES;
        fpe_pkg::ST_ERASE_SETUP:
        begin
          next_start = is_conf;
          next_error = !is_conf;
          next_state = is_conf ? fpe_pkg::ST_ERASE_BUSY : fpe_pkg::ST_READY;
        end
        fpe_pkg::ST_ERASE_BUSY:
          if (is_susp)
            next_state = fpe_pkg::ST_ERASE_SUSPEND;
        fpe_pkg::ST_ERASE_SUSPEND:
        begin
          if (is_wp)
            next_state = fpe_pkg::ST_WP_SETUP_ES; // [RULE2]
          else if (is_bp)
            next_state = fpe_pkg::ST_BP_SETUP_ES;
          else if (is_conf)
            next_state = fpe_pkg::ST_ERASE_BUSY;
        end
        fpe_pkg::ST_WP_SETUP_ES:
        begin
          next_start = 1'b1; // [RULE3]
          next_state = fpe_pkg::ST_WP_BUSY_ES; // [RULE3]
        end
        fpe_pkg::ST_WP_BUSY_ES:
          // Every other code, status, clear and query included, stays.
          if (is_susp)
            next_state = fpe_pkg::ST_WP_SUSPEND_ES; // [RULE4] [RULE5]
        fpe_pkg::ST_WP_SUSPEND_ES:
          if (is_conf)
            next_state = fpe_pkg::ST_WP_BUSY_ES;
        default:
          next_state = fpe_pkg::ST_READY;
      endcase
    end
    else if (i_op_done)
    begin
      case (state)
        fpe_pkg::ST_BP_BUSY, fpe_pkg::ST_ERASE_BUSY:
          next_state = fpe_pkg::ST_READY;
        fpe_pkg::ST_WP_BUSY_ES, fpe_pkg::ST_BP_BUSY_ES:
          next_state = fpe_pkg::ST_ERASE_SUSPEND;
        default:
          next_state = state;
      endcase
    end
  end

  // Read modes are kept apart from the state machine on purpose.
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      read_mode <= '0;
    else if (i_wr && !is_data) // [RULE7]
      for (int p = 0; p < NUM_PART; p++)
        if (i_wr_word.part == fpe_pkg::PART_W'(p))
          read_mode[2*p +: 2] <= mode_of(cmd, read_mode[2*p +: 2]); // [RULE7]
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state     <= fpe_pkg::ST_READY;
      count     <= '0;
      op_start  <= 1'b0;
      error     <= 1'b0;
      busy_part <= '0;
    end
    else
    begin
      state    <= next_state;
      count    <= next_count;
      op_start <= next_start;
      error    <= next_error;
      // One owner at a time: the partition latched at the start holds
      // until a new start, which can only follow completion or suspend.
      if (next_start)
        busy_part <= i_wr_word.part; // [RULE6]
    end
  end

  assign o_state     = state;
  assign o_op_start  = op_start;
  assign o_error     = error;
  assign o_busy_part = busy_part;
  assign o_read_mode = read_mode;

endmodule

// ### src/fpe_pkg.sv
/*
  Shared constants and types for the flash program/erase command
  sequencer: command codes, the state enumeration, the bus write
  carrier and the buffer word count limits.
  Assumes a 16-bit host data bus with one write strobe per cycle.
*/
package fpe_pkg;

  localparam int DATA_W = 16;
  localparam int CNT_W  = 5;
  localparam int PART_W = 3;

  localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
  localparam logic [7:0] CMD_WORD_PROG_A = 8'h10;
  localparam logic [7:0] CMD_WORD_PROG_B = 8'h40;
  localparam logic [7:0] CMD_BUF_PROG    = 8'hE8;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM     = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND     = 8'hB0;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLR_STATUS  = 8'h50;
  localparam logic [7:0] CMD_READ_ID     = 8'h90;
  localparam logic [7:0] CMD_QUERY       = 8'h98;

  localparam logic [1:0] RMODE_ARRAY  = 2'h0;
  localparam logic [1:0] RMODE_ID     = 2'h1;
  localparam logic [1:0] RMODE_QUERY  = 2'h2;
  localparam logic [1:0] RMODE_STATUS = 2'h3;

  typedef enum logic [4:0] {
    ST_READY,
    ST_BP_SETUP,
    ST_BP_LOAD1,
    ST_BP_LOAD2,
    ST_BP_CONFIRM,
    ST_BP_BUSY,
    ST_BP_SUSPEND,
    ST_ERASE_SETUP,
    ST_ERASE_BUSY,
    ST_ERASE_SUSPEND,
    ST_WP_SETUP_ES,
    ST_WP_BUSY_ES,
    ST_WP_SUSPEND_ES,
    ST_BP_SETUP_ES,
    ST_BP_LOAD1_ES,
    ST_BP_LOAD2_ES,
    ST_BP_CONFIRM_ES,
    ST_BP_BUSY_ES,
    ST_BP_SUSPEND_ES
  } fpe_state_type;

  typedef struct packed {
    logic [PART_W-1:0] part;
    logic [DATA_W-1:0] data;
  } fpe_write_type;

endpackage

// ### dv/fpe_monitor.sv
/* Port checker for the command sequencer.
   Assumes it is bound to every sequencer instance. */
`timescale 1ns/10ps
module fpe_monitor #(
  parameter int NUM_PART = 8
) (
  // Inputs of the sequencer
  input wire logic                         i_mclk,
  input wire logic                         i_arst_n,
  input wire logic                         i_wr,
  input wire fpe_pkg::fpe_write_type       i_wr_word,
  input wire logic                         i_op_done,
  // Outputs of the sequencer
  input wire fpe_pkg::fpe_state_type       o_state,
  input wire logic                         o_op_start,
  input wire logic                         o_error,
  input wire logic [fpe_pkg::PART_W-1:0]   o_busy_part,
  input wire logic [2*NUM_PART-1:0]        o_read_mode
);
  logic [7:0] c;
  assign c = i_wr_word.data[7:0];
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  a_load_hold: assert property (
    o_state == fpe_pkg::ST_BP_LOAD2 && i_wr |=> o_state inside
    {fpe_pkg::ST_BP_LOAD2, fpe_pkg::ST_BP_CONFIRM}) else $error("load");
  a_wp_enter: assert property (
    o_state == fpe_pkg::ST_ERASE_SUSPEND && i_wr && c inside {8'h10, 8'h40}
    |=> o_state == fpe_pkg::ST_WP_SETUP_ES) else $error("wp setup");
  a_wp_data: assert property (
    o_state == fpe_pkg::ST_WP_SETUP_ES && i_wr
    |=> o_state == fpe_pkg::ST_WP_BUSY_ES && o_op_start) else $error("wp");
  a_both_susp: assert property (
    o_state == fpe_pkg::ST_WP_BUSY_ES && i_wr && c == 8'hB0
    |=> o_state == fpe_pkg::ST_WP_SUSPEND_ES) else $error("suspend");
  a_busy_keep: assert property (
    o_state == fpe_pkg::ST_WP_BUSY_ES && i_wr && c inside {8'h70, 8'h50,
    8'h90, 8'h98} |=> $stable(o_state)) else $error("busy left");
  a_one_op: assert property (
    o_op_start |-> $past(o_state) inside {fpe_pkg::ST_BP_CONFIRM,
    fpe_pkg::ST_ERASE_SETUP, fpe_pkg::ST_WP_SETUP_ES,
    fpe_pkg::ST_BP_CONFIRM_ES}) else $error("start while busy");
  a_mode_keep: assert property (
    !i_wr |=> $stable(o_read_mode)) else $error("mode moved");
  a_data_mode: assert property (
    i_wr && o_state inside {fpe_pkg::ST_BP_SETUP, fpe_pkg::ST_BP_LOAD1,
    fpe_pkg::ST_BP_LOAD2, fpe_pkg::ST_WP_SETUP_ES, fpe_pkg::ST_BP_SETUP_ES,
    fpe_pkg::ST_BP_LOAD1_ES, fpe_pkg::ST_BP_LOAD2_ES}
    |=> $stable(o_read_mode)) else $error("data changed mode");
  a_bad_conf: assert property (
    o_state == fpe_pkg::ST_BP_CONFIRM && i_wr && c != 8'hD0
    |=> o_state == fpe_pkg::ST_READY && o_error) else $error("confirm");
  c_nested: cover property (o_state == fpe_pkg::ST_WP_SUSPEND_ES);
  c_error: cover property (o_error);
  c_start: cover property (o_op_start);
  c_bp_nested: cover property (o_state == fpe_pkg::ST_BP_BUSY_ES);
endmodule
bind fpe_command_fsm fpe_monitor #(.NUM_PART(NUM_PART)) u_mon (
  .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_wr(i_wr),
  .i_wr_word(i_wr_word), .i_op_done(i_op_done), .o_state(o_state),
  .o_op_start(o_op_start), .o_error(o_error),
  .o_busy_part(o_busy_part), .o_read_mode(o_read_mode));

// ### dv/fpe_wsm_model.sv
/* Behavioural write state machine beside the sequencer.
   Assumes it watches the sequencer state and answers with a done pulse. */
`timescale 1ns/10ps
module fpe_wsm_model #(
  parameter int DLY = 30
) (
  // Clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_arst_n,
  // Sequencer side
  input  wire fpe_pkg::fpe_state_type i_state,
  output logic                        o_done
);
  int   cnt;
  logic busy;
  // A suspend restarts the count, so a resumed job runs a full DLY again.
  assign busy = i_state inside {fpe_pkg::ST_BP_BUSY,
    fpe_pkg::ST_ERASE_BUSY, fpe_pkg::ST_WP_BUSY_ES, fpe_pkg::ST_BP_BUSY_ES};
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cnt    <= 0;
      o_done <= 1'h0;
    end
    else
    begin
      o_done <= busy && cnt == DLY - 1 && !o_done;
      cnt    <= (busy && !o_done) ? cnt + 1 : 0;
    end
  end
endmodule

// ### dv/fpe_command_fsm_tb.sv
/* Self-checking bench for the command sequencer.
   Assumes the write state machine model answers every busy period. */
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin failures++; \
  $display("mismatch %s exp %0h got %0h", n, e, s); end end
module fpe_command_fsm_tb;
  typedef struct packed {
    logic                   wr;
    logic [15:0]            d;
    fpe_pkg::fpe_state_type st;
  } fpe_row_type;
  logic                   i_mclk = 1'h0;
  logic                   i_arst_n = 1'h0;
  logic                   i_wr = 1'h0;
  fpe_pkg::fpe_write_type i_wr_word = 19'h0;
  logic                   i_op_done;
  fpe_pkg::fpe_state_type o_state;
  logic                   o_op_start;
  logic                   o_error;
  logic [2:0]             o_busy_part;
  logic [15:0]            o_read_mode;
  int                     failures = 0;
  int                     n_tests = 0;
  logic                   exp_go;
  fpe_pkg::fpe_state_type prev;
  logic [9:0]             mc [5] = '{10'h190, 10'h298, 10'h370, 10'h350,
                                     10'h0FF};
  fpe_row_type rows [30] = '{
    '{1'h1, 16'hE8, fpe_pkg::ST_BP_SETUP}, '{1'h1, 16'h0, fpe_pkg::ST_BP_LOAD1},
    '{1'h1, 16'h1, fpe_pkg::ST_BP_LOAD2}, '{1'h1, 16'hA, fpe_pkg::ST_BP_LOAD2},
    '{1'h1, 16'h5, fpe_pkg::ST_BP_CONFIRM}, '{1'h1, 16'hD0, fpe_pkg::ST_BP_BUSY},
    '{1'h0, 16'h0, fpe_pkg::ST_READY}, '{1'h1, 16'h20, fpe_pkg::ST_ERASE_SETUP},
    '{1'h1, 16'hD0, fpe_pkg::ST_ERASE_BUSY},
    '{1'h1, 16'hB0, fpe_pkg::ST_ERASE_SUSPEND},
    '{1'h1, 16'h40, fpe_pkg::ST_WP_SETUP_ES},
    '{1'h1, 16'h1234, fpe_pkg::ST_WP_BUSY_ES},
    '{1'h1, 16'h70, fpe_pkg::ST_WP_BUSY_ES}, '{1'h1, 16'h50, fpe_pkg::ST_WP_BUSY_ES},
    '{1'h1, 16'h90, fpe_pkg::ST_WP_BUSY_ES}, '{1'h1, 16'h98, fpe_pkg::ST_WP_BUSY_ES},
    '{1'h1, 16'hB0, fpe_pkg::ST_WP_SUSPEND_ES},
    '{1'h1, 16'hD0, fpe_pkg::ST_WP_BUSY_ES},
    '{1'h0, 16'h0, fpe_pkg::ST_ERASE_SUSPEND},
    '{1'h1, 16'h10, fpe_pkg::ST_WP_SETUP_ES},
    '{1'h1, 16'h0, fpe_pkg::ST_WP_BUSY_ES},
    '{1'h0, 16'h0, fpe_pkg::ST_ERASE_SUSPEND},
    '{1'h1, 16'hE8, fpe_pkg::ST_BP_SETUP_ES},
    '{1'h1, 16'h0, fpe_pkg::ST_BP_LOAD1_ES},
    '{1'h1, 16'h0, fpe_pkg::ST_BP_LOAD2_ES},
    '{1'h1, 16'h7, fpe_pkg::ST_BP_CONFIRM_ES},
    '{1'h1, 16'hD0, fpe_pkg::ST_BP_BUSY_ES},
    '{1'h0, 16'h0, fpe_pkg::ST_ERASE_SUSPEND},
    '{1'h1, 16'hD0, fpe_pkg::ST_ERASE_BUSY},
    '{1'h0, 16'h0, fpe_pkg::ST_READY}};
  fpe_command_fsm #(.NUM_PART(8)) dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .i_wr(i_wr), .i_wr_word(i_wr_word), .i_op_done(i_op_done),
    .o_state(o_state), .o_op_start(o_op_start), .o_error(o_error),
    .o_busy_part(o_busy_part), .o_read_mode(o_read_mode));
  fpe_wsm_model #(.DLY(30)) wsm (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .i_state(o_state), .o_done(i_op_done));
  task automatic wr(input logic [15:0] d, input logic [2:0] p = 3'h3);
    @(posedge i_mclk);
    i_wr      <= 1'h1;
    i_wr_word <= '{p, d};
    @(posedge i_mclk);
    i_wr      <= 1'h0;
    i_wr_word <= ~i_wr_word;
    #1;
  endtask
  task automatic wait_st(input fpe_pkg::fpe_state_type s);
    for (int n = 0; n < 200 && o_state !== s; n++)
      #4;
  endtask
  task automatic test_done();
    if (failures == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  forever
    #2 i_mclk = ~i_mclk;
  initial
  begin
    repeat (5000) @(posedge i_mclk);
    failures++;
    test_done();
  end
  initial
  begin
    repeat (20) @(posedge i_mclk);
    `CHK("rst state", fpe_pkg::ST_READY, o_state)
    `CHK("rst mode", 16'h0, o_read_mode)
    i_arst_n <= 1'h1;
    prev = fpe_pkg::ST_READY;
    foreach (rows[k])
    begin
      if (rows[k].wr)
        wr(rows[k].d);
      else
        wait_st(rows[k].st);
      `CHK("state", rows[k].st, o_state)
      `CHK("state", rows[k].st, o_state)
      // A start follows only the write taken in a setup or confirm state.
      exp_go = rows[k].wr && prev inside {fpe_pkg::ST_BP_CONFIRM,
        fpe_pkg::ST_ERASE_SETUP, fpe_pkg::ST_WP_SETUP_ES,
        fpe_pkg::ST_BP_CONFIRM_ES};
      `CHK("start", exp_go, o_op_start)
      `CHK("no error", 1'h0, o_error)
      prev = rows[k].st;
    end
    `CHK("part", 3'h3, o_busy_part)
    foreach (mc[k])
    begin
      wr({8'h00, mc[k][7:0]}, 3'h2);
      `CHK("mode", mc[k][9:8], o_read_mode[5:4])
      `CHK("ready", fpe_pkg::ST_READY, o_state)
    end
    `CHK("other mode", 2'h0, o_read_mode[3:2])
    foreach (mc[k])
      if (k < 4)
        wr(k == 0 ? 16'hE8 : (k == 3 ? 16'h90 : 16'h0));
    wr(16'h55);
    `CHK("error", 1'h1, o_error)
    `CHK("bad conf", fpe_pkg::ST_READY, o_state)
    `CHK("data mode", 2'h2, o_read_mode[7:6])
    wr(16'hE8);
    @(posedge i_mclk);
    i_arst_n <= 1'h0;
    #1;
    `CHK("mid rst", fpe_pkg::ST_READY, o_state)
    `CHK("mid rst mode", 16'h0, o_read_mode)
    repeat (2) @(posedge i_mclk);
    i_arst_n <= 1'h1;
    wr(16'h20);
    `CHK("after rst", fpe_pkg::ST_ERASE_SETUP, o_state)
    test_done();
  end
endmodule
